// file: dv/uart_channel_register_page_decoder_bench.sv
/*
 * self-checking bench for the register page decoder: walks pages 0..4
 * through host read and write tasks and compares answers and events.
 * assumes the engine model's status pattern and one-cycle answers.
 */
`timescale 1ns/1ps

module uart_channel_register_page_decoder_bench;
	import uart_page_pkg::*;

	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic clk, reset;               // clock and reset
	logic [1:0] chan;               // channel of the access
	logic [2:0] addr;               // register location
	logic wr_en, rd_en;             // strobes
	logic [7:0] wr_data, rd_data;   // bus bytes
	logic rd_valid;                 // read answer marker
	chan_stat_s stat [CHANNELS];    // engine status
	logic [7:0] gstate;             // global state byte
	chan_cfg_s cfg [CHANNELS];      // stored bytes
	evt_s evt;                      // side-effect events
	int err_total = 0;
	int tests_run = 0;

	uart_channel_page_decoder dut (.CLK(clk), .RESET(reset), .CHAN_SEL(chan), .ADDR(addr),
		.WR_EN(wr_en), .RD_EN(rd_en), .WR_DATA(wr_data), .RD_DATA(rd_data),
		.RD_VALID(rd_valid), .STAT(stat), .GLOBAL_STATE(gstate), .CFG(cfg), .EVT(evt));

	uart_engine_model engine (.stat(stat), .global_state(gstate));

	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	// expected engine byte for channel and field
	function automatic logic [7:0] sb(input int c, input int i);
		return 8'(8'h80 + c * 16 + i);
	endfunction : sb

	task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %s exp %h seen %h", n, exp, seen);
		end
	endtask : chk

	// one write, strobe dropped at the next falling edge
	task automatic wr(input int c, input int a, input logic [7:0] d);
		@(negedge clk);
		chan = 2'(c);
		addr = 3'(a);
		wr_data = d;
		wr_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
	endtask : wr

	// one read, answer checked at the falling edge half a cycle after the taking edge
	task automatic rd(input int c, input int a, input logic [7:0] exp);
		@(negedge clk);
		chan = 2'(c);
		addr = 3'(a);
		rd_en = 1'b1;
		@(negedge clk);
		rd_en = 1'b0;
		chk("rd_valid", rd_valid, 8'h01);
		chk($sformatf("rd c%0d a%0d", c, a), rd_data, exp);
	endtask : rd

	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		reset = 1'b1;
		chan = 2'h0;
		addr = 3'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		wr_data = 8'h00;
		repeat (3) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		rd(0, 3, 8'h00);
		rd(0, 7, 8'h00);
		$display("test reset done");
		// page 0: stored, status and event places
		wr(0, 1, 8'ha5);
		rd(0, 1, 8'ha5);
		wr(0, 7, 8'h3c);
		rd(0, 7, 8'h3c);
		wr(0, 4, 8'h0f);
		rd(0, 4, 8'h0f);
		wr(0, 5, 8'hff);
		rd(0, 5, sb(0, 3));
		rd(0, 6, sb(0, 4));
		rd(0, 0, sb(0, 1));
		chk("rx_pop", evt.rx_pop, 8'h01);
		wr(0, 0, 8'hc3);
		chk("tx_load", evt.tx_load, 8'h01);
		chk("evt data", evt.data, 8'hc3);
		rd(0, 2, sb(0, 2));
		wr(0, 2, 8'h07);
		chk("fifo_load", evt.fifo_load, 8'h01);
		chk("cfg modem ctrl", cfg[0].modem_ctrl_reg, 8'h0f);
		rd(1, 7, 8'h00);
		rd(2, 5, sb(2, 3));
		wr(3, 7, 8'h99);
		chk("evt chan", evt.chan, 8'h03);
		rd(3, 7, 8'h99);
		$display("test page0 done");
		// page 1: divisor bytes, shared places
		wr(0, 3, 8'h80);
		wr(0, 0, 8'h11);
		wr(0, 1, 8'h22);
		rd(0, 0, 8'h11);
		rd(0, 1, 8'h22);
		rd(0, 2, sb(0, 2));
		rd(0, 6, sb(0, 4));
		rd(0, 7, 8'h3c);
		rd(0, 4, 8'h0f);
		chk("cfg div high", cfg[0].divisor_high, 8'h22);
		wr(0, 3, 8'h00);
		rd(0, 0, sb(0, 1));
		rd(0, 1, 8'ha5);
		$display("test page1 done");
		// page 2: global and count places
		wr(0, 4, 8'h4f);
		rd(0, 0, 8'h00);
		wr(0, 0, 8'h77);
		chk("tx_load p2", evt.tx_load, 8'h00);
		wr(0, 1, 8'he1);
		chk("gctrl_load", evt.gctrl_load, 8'h01);
		rd(0, 1, 8'h00);
		rd(0, 2, 8'h5a);
		for (int a = 5; a < 8; a++) rd(0, a, sb(0, a));
		rd(0, 4, 8'h4f);
		wr(0, 7, 8'h55);
		$display("test page2 done");
		// pages 3 and 4: line format key wins over page-two bit
		wr(0, 3, 8'hbf);
		rd(0, 0, 8'h00);
		for (int a = 1; a < 8; a++) if (a != 3) wr(0, a, 8'(8'h30 + a));
		wr(0, 0, 8'h01);
		rd(0, 0, 8'h01);
		for (int a = 1; a < 8; a++) if (a != 3) wr(0, a, 8'(8'h40 + a));
		for (int a = 1; a < 8; a++) if (a != 3) rd(0, a, 8'(8'h40 + a));
		rd(0, 3, 8'hbf);
		wr(0, 0, 8'h00);
		for (int a = 1; a < 8; a++) if (a != 3) rd(0, a, 8'(8'h30 + a));
		chk("cfg enh", cfg[0].enhanced_ctrl_reg, 8'h32);
		$display("test page3 page4 done");
		// back to page 0: read-only write left scratch alone
		wr(0, 3, 8'h03);
		rd(0, 4, 8'h4f);
		wr(0, 4, 8'h00);
		rd(0, 7, 8'h3c);
		rd(0, 3, 8'h03);
		// read and write in one cycle: write lands, no read answer
		@(negedge clk);
		addr = 3'h7;
		wr_data = 8'h6e;
		wr_en = 1'b1;
		rd_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
		rd_en = 1'b0;
		chk("clash rd_valid", rd_valid, 8'h00);
		chk("clash rd_data", rd_data, 8'h00);
		rd(0, 7, 8'h6e);
		$display("test return done");
		end_sim();
	end

	// watchdog, far beyond the couple of hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		end_sim();
	end

endmodule : uart_channel_register_page_decoder_bench

// file: dv/uart_engine_model.sv
/*
 * stand-in for the serial engine behind the page decoder: drives a fixed,
 * distinct status byte per channel and field, and a global state byte.
 * assumes the bench reads these through the decoder and derives the same
 * bytes on its own from channel and field number.
 */
`timescale 1ns/1ps

module uart_engine_model (
	// status toward the decoder
	output uart_page_pkg::chan_stat_s stat [uart_page_pkg::CHANNELS],
	output logic [7:0] global_state
);
	import uart_page_pkg::*;

	// ------------------------------------------------------------
	// status pattern
	// ------------------------------------------------------------
	// byte = 80h + channel * 10h + field number (1..7)
	function automatic logic [7:0] sb(input int c, input int i);
		return 8'(8'h80 + c * 16 + i);
	endfunction : sb

	// fields in struct order: rx_buffer first, flow_state_reg last
	always_comb begin
		for (int c = 0; c < CHANNELS; c++) begin
			stat[c] = {sb(c, 1), sb(c, 2), sb(c, 3), sb(c, 4), sb(c, 5), sb(c, 6), sb(c, 7)};
		end
		global_state = 8'h5a;
	end

endmodule : uart_engine_model

// file: verilog/uart_channel_page_decoder.sv
/*
 * register page decoder for the four channels of a quad uart: stores the
 * programmable bytes of every channel, picks a page from the current
 * line_format_reg, modem_ctrl_reg and bank_select_reg of the addressed
 * channel, routes reads and writes, and reports side-effect accesses.
 * assumes host bus logic on CLK giving one-cycle RD_EN / WR_EN strobes.
 */
// How it works
// R01 - four channel sets, three address bits each
// R02 - page 0 when divisor bit and page-two bit low
// R03 - page 1 when divisor bit set, not BFh
// R04 - page 2 when divisor bit low, page-two set
// R05 - page 3 when BFh and bank bit low
// R06 - page 4 when BFh and bank bit high
// R07 - page 0 location 0: write tx, read rx
// R08 - page 0 location 1: interrupt enable read/write
// R09 - pages 0/1 location 2: fifo write, source read
// R10 - location 3 always line format, read/write
// R11 - location 4 modem control in pages 0-2
// R12 - line/modem state read-only, scratch read/write
// R13 - page 1 divisor low/high bytes read/write
// R14 - page 2: nothing at 0, global control write-only
// R15 - page 2 global state read-only at 2
// R16 - page 2 fill counts and flow state read-only
// R17 - bank select at 0 in pages 3, 4
// R18 - page 3 auto toggle, enhanced control read/write
// R19 - page 3 resume and stop characters read/write
// R20 - page 4 extra feature, resend count read/write
// R21 - page 4 trigger levels read/write
// R22 - page 4 flow thresholds read/write
// R23 - page chosen from current contents per access
// R24 - read-only writes ignored; empty reads zero
`timescale 1ns/1ps

module uart_channel_page_decoder (
	// clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// host register bus
	input wire logic [uart_page_pkg::CHAN_W-1:0] CHAN_SEL,
	input wire logic [uart_page_pkg::ADDR_W-1:0] ADDR,
	input wire logic WR_EN,
	input wire logic RD_EN,
	input wire logic [7:0] WR_DATA,
	output logic [7:0] RD_DATA,
	output logic RD_VALID,
	// serial engine side
	input wire uart_page_pkg::chan_stat_s STAT [uart_page_pkg::CHANNELS],
	input wire logic [7:0] GLOBAL_STATE,
	output uart_page_pkg::chan_cfg_s CFG [uart_page_pkg::CHANNELS],
	output uart_page_pkg::evt_s EVT
);
	import uart_page_pkg::*;

	// ----------------------------------------------------------------
	// page and register selection
	// ----------------------------------------------------------------

	// page from the three selecting registers
	function automatic page_e page_of(input chan_cfg_s c);
		if (c.line_format_reg == FMT_ENHANCED_KEY) begin
			page_of = c.bank_select_reg[BANK_BIT] ? PAGE_4 : PAGE_3; // R05 R06
		end else if (c.line_format_reg[FMT_DIV_BIT]) begin
			page_of = PAGE_1; // R03
		end else if (c.modem_ctrl_reg[MODEM_PAGE2_BIT]) begin
			page_of = PAGE_2; // R04
		end else begin
			page_of = PAGE_0; // R02
		end
	endfunction : page_of

	// register at a location of a page
	function automatic reg_sel_e sel_of(input page_e pg, input logic [2:0] a);
		sel_of = SEL_NONE;
		if (a == OFS_LINE_FMT) begin
			sel_of = SEL_LINE_FMT; // R10
		end else begin
			case (pg)
				PAGE_0, PAGE_1: begin
					case (a)
						OFS_TXRX: sel_of = (pg == PAGE_0) ? SEL_TXRX : SEL_DIV_LO; // R07 R13
						OFS_INT_EN: sel_of = (pg == PAGE_0) ? SEL_INT_EN : SEL_DIV_HI; // R08 R13
						OFS_FIFO_SRC: sel_of = SEL_FIFO_SRC; // R09
						OFS_MODEM_CTRL: sel_of = SEL_MODEM_CTRL; // R11
						OFS_LINE_STATE: sel_of = SEL_LINE_STATE; // R12
						OFS_MODEM_STATE: sel_of = SEL_MODEM_STATE; // R12
						OFS_SCRATCH: sel_of = SEL_SCRATCH; // R12
						default: sel_of = SEL_NONE;
					endcase
				end
				PAGE_2: begin
					case (a)
						OFS_GCTRL: sel_of = SEL_GCTRL; // R14
						OFS_GSTATE: sel_of = SEL_GSTATE; // R15
						OFS_MODEM_CTRL: sel_of = SEL_MODEM_CTRL; // R11
						OFS_TCNT: sel_of = SEL_TCNT; // R16
						OFS_RCNT: sel_of = SEL_RCNT; // R16
						OFS_FLOW_STATE: sel_of = SEL_FLOW_STATE; // R16
						default: sel_of = SEL_NONE; // R14
					endcase
				end
				PAGE_3: begin
					case (a)
						OFS_BANK: sel_of = SEL_BANK; // R17
						OFS_TOGGLE: sel_of = SEL_TOGGLE; // R18
						OFS_ENH: sel_of = SEL_ENH; // R18
						OFS_RESUME1: sel_of = SEL_RESUME1; // R19
						OFS_RESUME2: sel_of = SEL_RESUME2; // R19
						OFS_STOP1: sel_of = SEL_STOP1; // R19
						OFS_STOP2: sel_of = SEL_STOP2; // R19
						default: sel_of = SEL_NONE;
					endcase
				end
				PAGE_4: begin
					case (a)
						OFS_BANK: sel_of = SEL_BANK; // R17
						OFS_EXTRA: sel_of = SEL_EXTRA; // R20
						OFS_RESEND: sel_of = SEL_RESEND; // R20
						OFS_TX_TRIG: sel_of = SEL_TX_TRIG; // R21
						OFS_RX_TRIG: sel_of = SEL_RX_TRIG; // R21
						OFS_FLOW_UP: sel_of = SEL_FLOW_UP; // R22
						OFS_FLOW_LOW: sel_of = SEL_FLOW_LOW; // R22
						default: sel_of = SEL_NONE;
					endcase
				end
				default: sel_of = SEL_NONE;
			endcase
		end
	endfunction : sel_of

	// byte returned for a read; write-only and empty read as zero
	function automatic logic [7:0] read_of(input reg_sel_e s, input chan_cfg_s c,
		input chan_stat_s t, input logic [7:0] g);
		case (s)
			SEL_TXRX: read_of = t.rx_buffer; // R07
			SEL_INT_EN: read_of = c.int_enable_reg; // R08
			SEL_FIFO_SRC: read_of = t.int_source_reg; // R09
			SEL_LINE_FMT: read_of = c.line_format_reg; // R10
			SEL_MODEM_CTRL: read_of = c.modem_ctrl_reg; // R11
			SEL_LINE_STATE: read_of = t.line_state_reg; // R12
			SEL_MODEM_STATE: read_of = t.modem_state_reg; // R12
			SEL_SCRATCH: read_of = c.scratch_reg; // R12
			SEL_DIV_LO: read_of = c.divisor_low; // R13
			SEL_DIV_HI: read_of = c.divisor_high; // R13
			SEL_GSTATE: read_of = g; // R15
			SEL_TCNT: read_of = t.tx_fill_count; // R16
			SEL_RCNT: read_of = t.rx_fill_count; // R16
			SEL_FLOW_STATE: read_of = t.flow_state_reg; // R16
			SEL_BANK: read_of = c.bank_select_reg; // R17
			SEL_TOGGLE: read_of = c.auto_toggle_reg; // R18
			SEL_ENH: read_of = c.enhanced_ctrl_reg; // R18
			SEL_RESUME1: read_of = c.resume_char_first; // R19
			SEL_RESUME2: read_of = c.resume_char_second; // R19
			SEL_STOP1: read_of = c.stop_char_first; // R19
			SEL_STOP2: read_of = c.stop_char_second; // R19
			SEL_EXTRA: read_of = c.extra_feature_reg; // R20
			SEL_RESEND: read_of = c.stop_resend_count; // R20
			SEL_TX_TRIG: read_of = c.tx_trigger_reg; // R21
			SEL_RX_TRIG: read_of = c.rx_trigger_reg; // R21
			SEL_FLOW_UP: read_of = c.flow_upper_reg; // R22
			SEL_FLOW_LOW: read_of = c.flow_lower_reg; // R22
			default: read_of = READ_EMPTY; // R24
		endcase
	endfunction : read_of

	// ----------------------------------------------------------------
	// storage and decode wires
	// ----------------------------------------------------------------
	chan_cfg_s cfg_q [CHANNELS];    // programmable bytes per channel
	evt_s evt_q;                    // side-effect report
	logic [7:0] rd_data_q;          // registered read answer
	logic rd_valid_q;               // read answer marker

	wire chan_cfg_s cur_cfg = cfg_q[CHAN_SEL];        // addressed channel R01
	page_e cur_page; // live page R23
	assign cur_page = page_of(cur_cfg);
	reg_sel_e cur_sel; // target register R01
	assign cur_sel = sel_of(cur_page, ADDR);
	wire acc_wr = WR_EN;                              // write wins a clash
	wire acc_rd = RD_EN && !WR_EN;                    // read when no write
	wire logic [7:0] rd_mux = read_of(cur_sel, cur_cfg, STAT[CHAN_SEL], GLOBAL_STATE);
	wire rx_pop_d = acc_rd && (cur_sel == SEL_TXRX);  // read consumes rx byte

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------

	// store writable bytes; read-only and empty locations drop the write
	always_ff @(posedge CLK) begin
		if (RESET) begin
			for (int i = 0; i < CHANNELS; i++) begin
				cfg_q[i] <= '0;
			end
		end else if (acc_wr) begin
			case (cur_sel)
				SEL_INT_EN: cfg_q[CHAN_SEL].int_enable_reg <= WR_DATA; // R08
				SEL_LINE_FMT: cfg_q[CHAN_SEL].line_format_reg <= WR_DATA; // R10
				SEL_MODEM_CTRL: cfg_q[CHAN_SEL].modem_ctrl_reg <= WR_DATA; // R11
				SEL_SCRATCH: cfg_q[CHAN_SEL].scratch_reg <= WR_DATA; // R12
				SEL_DIV_LO: cfg_q[CHAN_SEL].divisor_low <= WR_DATA; // R13
				SEL_DIV_HI: cfg_q[CHAN_SEL].divisor_high <= WR_DATA; // R13
				SEL_GCTRL: cfg_q[CHAN_SEL].global_int_ctrl <= WR_DATA; // R14
				SEL_BANK: cfg_q[CHAN_SEL].bank_select_reg <= WR_DATA; // R17
				SEL_TOGGLE: cfg_q[CHAN_SEL].auto_toggle_reg <= WR_DATA; // R18
				SEL_ENH: cfg_q[CHAN_SEL].enhanced_ctrl_reg <= WR_DATA; // R18
				SEL_RESUME1: cfg_q[CHAN_SEL].resume_char_first <= WR_DATA; // R19
				SEL_RESUME2: cfg_q[CHAN_SEL].resume_char_second <= WR_DATA; // R19
				SEL_STOP1: cfg_q[CHAN_SEL].stop_char_first <= WR_DATA; // R19
				SEL_STOP2: cfg_q[CHAN_SEL].stop_char_second <= WR_DATA; // R19
				SEL_EXTRA: cfg_q[CHAN_SEL].extra_feature_reg <= WR_DATA; // R20
				SEL_RESEND: cfg_q[CHAN_SEL].stop_resend_count <= WR_DATA; // R20
				SEL_TX_TRIG: cfg_q[CHAN_SEL].tx_trigger_reg <= WR_DATA; // R21
				SEL_RX_TRIG: cfg_q[CHAN_SEL].rx_trigger_reg <= WR_DATA; // R21
				SEL_FLOW_UP: cfg_q[CHAN_SEL].flow_upper_reg <= WR_DATA; // R22
				SEL_FLOW_LOW: cfg_q[CHAN_SEL].flow_lower_reg <= WR_DATA; // R22
				default: ; // R24
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read answer and access events
	// ----------------------------------------------------------------

	// one-cycle read answer, zero when idle
	always_ff @(posedge CLK) begin
		if (RESET) begin
			rd_data_q <= REG_RESET;
			rd_valid_q <= 1'b0;
		end else begin
			rd_data_q <= acc_rd ? rd_mux : READ_EMPTY; // R24
			rd_valid_q <= acc_rd;
		end
	end

	// one-cycle pulses for holding, fifo and global writes and rx reads
	always_ff @(posedge CLK) begin
		if (RESET) begin
			evt_q <= '0;
		end else begin
			evt_q.tx_load <= acc_wr && (cur_sel == SEL_TXRX); // R07
			evt_q.fifo_load <= acc_wr && (cur_sel == SEL_FIFO_SRC); // R09
			evt_q.gctrl_load <= acc_wr && (cur_sel == SEL_GCTRL); // R14
			evt_q.rx_pop <= rx_pop_d; // R07
			evt_q.chan <= CHAN_SEL;
			evt_q.data <= acc_wr ? WR_DATA : READ_EMPTY;
		end
	end

	// outputs straight from flops
	assign RD_DATA = rd_data_q;
	assign RD_VALID = rd_valid_q;
	assign CFG = cfg_q;
	assign EVT = evt_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	// previous access channel for checks
	logic [CHAN_W-1:0] chan_past_q;
	always_ff @(posedge CLK) begin
		chan_past_q <= CHAN_SEL;
	end

	property p_page0;
		!cur_cfg.line_format_reg[FMT_DIV_BIT] && !cur_cfg.modem_ctrl_reg[MODEM_PAGE2_BIT]
			|-> cur_page == PAGE_0;
	endproperty
	a_page0: assert property (p_page0) else $error("page 0 not chosen"); // R02

	property p_page1;
		cur_cfg.line_format_reg[FMT_DIV_BIT] && cur_cfg.line_format_reg != FMT_ENHANCED_KEY
			|-> cur_page == PAGE_1;
	endproperty
	a_page1: assert property (p_page1) else $error("page 1 not chosen"); // R03

	property p_page2;
		!cur_cfg.line_format_reg[FMT_DIV_BIT] && cur_cfg.modem_ctrl_reg[MODEM_PAGE2_BIT]
			|-> cur_page == PAGE_2;
	endproperty
	a_page2: assert property (p_page2) else $error("page 2 not chosen"); // R04

	property p_page34;
		cur_cfg.line_format_reg == FMT_ENHANCED_KEY
			|-> cur_page == (cur_cfg.bank_select_reg[BANK_BIT] ? PAGE_4 : PAGE_3);
	endproperty
	a_page34: assert property (p_page34) else $error("page 3/4 wrong"); // R05 R06

	// bank select reachable and writable from both enhanced pages
	property p_bank_write;
		acc_wr && (cur_page == PAGE_3 || cur_page == PAGE_4) && ADDR == OFS_BANK
			|=> CFG[chan_past_q].bank_select_reg == $past(WR_DATA);
	endproperty
	a_bank_write: assert property (p_bank_write) else $error("bank select write lost"); // R17

	property p_tx_load;
		acc_wr && cur_page == PAGE_0 && ADDR == OFS_TXRX
			|=> EVT.tx_load && EVT.data == $past(WR_DATA) && !RD_VALID;
	endproperty
	a_tx_load: assert property (p_tx_load) else $error("holding write lost"); // R07

	property p_rx_read;
		acc_rd && cur_page == PAGE_0 && ADDR == OFS_TXRX
			|=> RD_VALID && EVT.rx_pop && RD_DATA == $past(STAT[CHAN_SEL].rx_buffer);
	endproperty
	a_rx_read: assert property (p_rx_read) else $error("rx read wrong"); // R07

	property p_lcr_any_page;
		acc_wr && ADDR == OFS_LINE_FMT
			|=> CFG[chan_past_q].line_format_reg == $past(WR_DATA) ##1 1'b1;
	endproperty
	a_lcr_any_page: assert property (p_lcr_any_page) else $error("line format write lost"); // R10

	property p_div_low;
		acc_wr && cur_page == PAGE_1 && ADDR == OFS_DIV_LOW
			|=> CFG[chan_past_q].divisor_low == $past(WR_DATA);
	endproperty
	a_div_low: assert property (p_div_low) else $error("divisor low lost"); // R13

	property p_ro_write;
		acc_wr && cur_page == PAGE_2 && (ADDR == OFS_TCNT || ADDR == OFS_FLOW_STATE)
			|=> CFG[chan_past_q] == $past(cur_cfg);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only write stored"); // R24

	property p_wo_read;
		acc_rd && cur_page == PAGE_2 && (ADDR == OFS_GCTRL || ADDR == 3'h0)
			|=> RD_VALID && RD_DATA == READ_EMPTY;
	endproperty
	a_wo_read: assert property (p_wo_read) else $error("write-only read not zero"); // R14

	property p_fill_read;
		acc_rd && cur_page == PAGE_2 && ADDR == OFS_RCNT
			|=> RD_DATA == $past(STAT[CHAN_SEL].rx_fill_count);
	endproperty
	a_fill_read: assert property (p_fill_read) else $error("fill count wrong"); // R16

	c_page3: cover property (acc_wr && cur_page == PAGE_3 && ADDR == OFS_RESUME1);
	c_page4: cover property (acc_rd && cur_page == PAGE_4 && ADDR == OFS_FLOW_LOW);
	c_bank_switch: cover property (acc_wr && cur_sel == SEL_BANK ##1 cur_page == PAGE_4);
	c_fifo_load: cover property (EVT.fifo_load);

endmodule : uart_channel_page_decoder

// file: verilog/uart_page_pkg.sv
/*
 * shared definitions for the per-channel register page decoder: address
 * offsets, page-select fields, reset values, register selectors and the
 * packed carriers for configuration, status and access events.
 * assumes a single clock domain shared with the host register bus logic.
 */
package uart_page_pkg;

	// ----------------------------------------------------------------
	// bus geometry
	// ----------------------------------------------------------------
	localparam int CHANNELS = 4;          // channels, each with its own set
	localparam int CHAN_W = 2;            // channel select width
	localparam int ADDR_W = 3;            // register location width

	// ----------------------------------------------------------------
	// register locations within a page
	// ----------------------------------------------------------------
	localparam logic [2:0] OFS_TXRX = 3'h0; // tx_holding / rx_buffer
	localparam logic [2:0] OFS_DIV_LOW = 3'h0; // divisor low byte
	localparam logic [2:0] OFS_BANK = 3'h0; // bank_select_reg
	localparam logic [2:0] OFS_INT_EN = 3'h1; // int_enable_reg
	localparam logic [2:0] OFS_DIV_HIGH = 3'h1; // divisor_high
	localparam logic [2:0] OFS_GCTRL = 3'h1; // global_int_ctrl
	localparam logic [2:0] OFS_TOGGLE = 3'h1; // auto_toggle_reg
	localparam logic [2:0] OFS_EXTRA = 3'h1; // extra_feature_reg
	localparam logic [2:0] OFS_FIFO_SRC = 3'h2; // fifo_ctrl_reg / int_source_reg
	localparam logic [2:0] OFS_GSTATE = 3'h2; // global_int_state
	localparam logic [2:0] OFS_ENH = 3'h2; // enhanced_ctrl_reg
	localparam logic [2:0] OFS_RESEND = 3'h2; // stop_resend_count
	localparam logic [2:0] OFS_LINE_FMT = 3'h3; // line_format_reg
	localparam logic [2:0] OFS_MODEM_CTRL = 3'h4; // modem_ctrl_reg
	localparam logic [2:0] OFS_RESUME1 = 3'h4; // resume_char_first
	localparam logic [2:0] OFS_TX_TRIG = 3'h4; // tx_trigger_reg
	localparam logic [2:0] OFS_LINE_STATE = 3'h5; // line_state_reg
	localparam logic [2:0] OFS_TCNT = 3'h5; // tx_fill_count
	localparam logic [2:0] OFS_RESUME2 = 3'h5; // resume_char_second
	localparam logic [2:0] OFS_RX_TRIG = 3'h5; // rx_trigger_reg
	localparam logic [2:0] OFS_MODEM_STATE = 3'h6; // modem_state_reg
	localparam logic [2:0] OFS_RCNT = 3'h6; // rx_fill_count
	localparam logic [2:0] OFS_STOP1 = 3'h6; // stop_char_first
	localparam logic [2:0] OFS_FLOW_UP = 3'h6; // flow_upper_reg
	localparam logic [2:0] OFS_SCRATCH = 3'h7; // scratch_reg
	localparam logic [2:0] OFS_FLOW_STATE = 3'h7; // flow_state_reg
	localparam logic [2:0] OFS_STOP2 = 3'h7; // stop_char_second
	localparam logic [2:0] OFS_FLOW_LOW = 3'h7; // flow_lower_reg

	// ----------------------------------------------------------------
	// page-select fields and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] FMT_ENHANCED_KEY = 8'hbf; // opens pages 3 and 4
	localparam int FMT_DIV_BIT = 7; // divisor-access bit
	localparam int MODEM_PAGE2_BIT = 6; // page-two bit
	localparam int BANK_BIT = 0;                      // page 3 / page 4 bit
	localparam logic [7:0] REG_RESET = 8'h00;         // every stored byte
	localparam logic [7:0] READ_EMPTY = 8'h00;        // unmapped / write-only read

	// ----------------------------------------------------------------
	// pages and register selectors
	// ----------------------------------------------------------------
	typedef enum {PAGE_0, PAGE_1, PAGE_2, PAGE_3, PAGE_4} page_e;

	typedef enum {SEL_NONE, SEL_TXRX, SEL_INT_EN, SEL_FIFO_SRC, SEL_LINE_FMT, SEL_MODEM_CTRL,
		SEL_LINE_STATE, SEL_MODEM_STATE, SEL_SCRATCH, SEL_DIV_LO, SEL_DIV_HI, SEL_GCTRL,
		SEL_GSTATE, SEL_TCNT, SEL_RCNT, SEL_FLOW_STATE, SEL_BANK, SEL_TOGGLE, SEL_ENH,
		SEL_RESUME1, SEL_RESUME2, SEL_STOP1, SEL_STOP2, SEL_EXTRA, SEL_RESEND, SEL_TX_TRIG,
		SEL_RX_TRIG, SEL_FLOW_UP, SEL_FLOW_LOW} reg_sel_e;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] line_format_reg;
		logic [7:0] modem_ctrl_reg;
		logic [7:0] bank_select_reg;
		logic [7:0] int_enable_reg;
		logic [7:0] scratch_reg;
		logic [7:0] divisor_low;
		logic [7:0] divisor_high;
		logic [7:0] global_int_ctrl;
		logic [7:0] auto_toggle_reg;
		logic [7:0] enhanced_ctrl_reg;
		logic [7:0] resume_char_first;
		logic [7:0] resume_char_second;
		logic [7:0] stop_char_first;
		logic [7:0] stop_char_second;
		logic [7:0] extra_feature_reg;
		logic [7:0] stop_resend_count;
		logic [7:0] tx_trigger_reg;
		logic [7:0] rx_trigger_reg;
		logic [7:0] flow_upper_reg;
		logic [7:0] flow_lower_reg;
	} chan_cfg_s;

	typedef struct packed {
		logic [7:0] rx_buffer;
		logic [7:0] int_source_reg;
		logic [7:0] line_state_reg;
		logic [7:0] modem_state_reg;
		logic [7:0] tx_fill_count;
		logic [7:0] rx_fill_count;
		logic [7:0] flow_state_reg;
	} chan_stat_s;

	typedef struct packed {
		logic tx_load;             // byte for tx_holding
		logic fifo_load;           // byte for fifo_ctrl_reg
		logic gctrl_load;          // byte for global_int_ctrl
		logic rx_pop;              // rx_buffer was read
		logic [CHAN_W-1:0] chan;   // channel of the event
		logic [7:0] data;          // written byte
	} evt_s;

endpackage : uart_page_pkg
